// [logic/gms_gauge_mem.sv]
`include "gms_consts.svh"
`default_nettype none

// Function
// R1 - user block lock flag reads at bit 0 of lock control, default 0
// R2 - bus slave address lives in parameter block at 7Eh
// R3 - host sets address write enable, then writes 7Eh
// R4 - new slave address takes effect right after the 7Eh write
// R5 - new slave address reaches cells only on parameter block copy
// R6 - power cycle before that copy restores the stored address
// R7 - host keeps the address write enable cleared when not programming
// R8 - address byte carries seven address bits in 7..1, bit 0 reserved
// R9 - factory slave address is 0110100b
// R10 - one linear byte space of 256 locations
// R11 - reserved reads undefined; host never writes reserved bytes
// R12 - pair MSB at even address, LSB at the following odd one
// R13 - reading pair MSB captures both bytes until the read command ends
// R14 - host reads both pair bytes within one read command
// R15 - host reads and writes touch shadow RAM only, never cells
// R16 - copy moves shadow into cells, recall moves cells into shadow
// R17 - host writes shadow then copies; recalls then reads to verify
// R18 - sixteen byte user block at 20h..2Fh affects nothing else
// R19 - locked user block refuses all writes
// R20 - parameter block spans 60h..7Fh
// R21 - each 4% capacity boundary crossing saves charge and age bytes
// R22 - parameter block lock flag reads at bit 1, default 0
// R23 - special feature register reads and writes at 15h
// R24 - copy and recall issued by writing command register FEh
// R25 - at power up all shadow blocks load from cells before serving
// R26 - copy to a locked block leaves its cells unchanged
module gms_gauge_mem
    import gms_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       bus_req,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_cmd_end,
    output var  logic       bus_ack,
    output var  logic [7:0] bus_rdata,
    input  wire logic       meas_we,
    input  wire logic [7:0] meas_addr,
    input  wire logic [7:0] meas_data,
    output var  logic       meas_ready,
    input  wire logic [7:0] remaining_relative_capacity,
    output var  logic [6:0] slave_addr_bits,
    output var  logic       user_block_lock_flag,
    output var  logic       param_block_lock_flag
);
    // ************************************************************
    // storage
    // ************************************************************
    gms_mem_if #(.AW(8)) sh ();
    gms_mem_if #(.AW(6)) nv ();

    gms_nv_mem #(.AW(8)) u_shadow (.sys_clk(sys_clk), .ce(ce), .port(sh));
    gms_nv_mem #(.AW(6)) u_cells  (.sys_clk(sys_clk), .ce(ce), .port(nv));

    gms_state_t state;
    gms_state_t next_state;
    gms_byte_t  special_feature_reg;
    logic [5:0] xf_idx;
    logic [5:0] xf_last;
    logic [5:0] xf_pidx;
    logic       xf_run;
    logic       xf_pend;
    logic       xf_to_nv;
    logic [5:0] remaining_relative_capacity_bkt;
    logic       remaining_relative_capacity_seen;
    logic       bk_pend;
    gms_byte_t  lat_lsb;
    logic [7:0] lat_addr;
    logic       lat_ok;

    // cell index to byte address of its shadow copy
    function automatic logic [7:0] nv2sh(input logic [5:0] idx);
        logic [7:0] a;
        a = {2'b00, idx};
        if (idx <= `GMS_NV_UB_LAST)
            return 8'(a + `GMS_UB_BASE);
        else if (idx <= `GMS_NV_PB_LAST)
            return 8'(a + `GMS_PB_BASE - 8'h10); // R20
        else if (idx == `GMS_NV_BK_FIRST)
            return `GMS_ADDR_ACC_MSB;
        else if (idx == `GMS_NV_BK_ACC_LSB)
            return `GMS_ADDR_ACC_LSB;
        else
            return `GMS_ADDR_AGE;
    endfunction

    // ************************************************************
    // request decode
    // ************************************************************
    wire idle      = (state == ST_IDLE);
    wire xfer_act  = (state == ST_INIT) || (state == ST_XFER);
    wire meas_take = idle && meas_we && meas_ready;
    wire host_go   = idle && bus_req && !bus_ack && !meas_take;
    wire hw        = host_go && bus_wr;
    wire hr        = host_go && !bus_wr;
    wire bk_go     = idle && bk_pend && !meas_take && !host_go;
    wire addr_we   = special_feature_reg[`GMS_BIT_ADDR_WE];
    wire in_ub     = (bus_addr >= `GMS_UB_BASE) && (bus_addr <= `GMS_UB_LAST);
    wire a_sfr     = (bus_addr == `GMS_ADDR_SFR);
    wire a_nvctl   = (bus_addr == `GMS_ADDR_NVCTL);
    wire a_fcmd    = (bus_addr == `GMS_ADDR_FCMD);
    wire a_slave   = (bus_addr == `GMS_ADDR_SLAVE);
    wire is_pair   = (bus_addr >= `GMS_PAIR_LO) && (bus_addr <= `GMS_PAIR_HI)
                     && !bus_addr[0] && (bus_addr != `GMS_ADDR_REMAINING_RELATIVE_CAPACITY)
                     && (bus_addr != `GMS_ADDR_AGE);
    wire wr_sfr    = hw && a_sfr;
    wire wr_slave  = hw && a_slave && addr_we;
    wire wr_fc     = hw && a_fcmd;
    wire ub_refuse = in_ub && user_block_lock_flag;
    wire ram_hw    = hw && !a_sfr && !a_nvctl && !a_fcmd && !ub_refuse
                     && !(a_slave && !addr_we);
    wire fc_copy0  = wr_fc && (bus_wdata == `GMS_FC_COPY0) && !user_block_lock_flag; // R26
    wire fc_copy1  = wr_fc && (bus_wdata == `GMS_FC_COPY1) && !param_block_lock_flag;
    wire fc_rec0   = wr_fc && (bus_wdata == `GMS_FC_RECALL0);
    wire fc_rec1   = wr_fc && (bus_wdata == `GMS_FC_RECALL1);
    wire fc_lock0  = wr_fc && (bus_wdata == `GMS_FC_LOCK0);
    wire fc_lock1  = wr_fc && (bus_wdata == `GMS_FC_LOCK1);
    wire blk0      = fc_copy0 || fc_rec0;
    wire blk1      = fc_copy1 || fc_rec1;
    wire launch    = blk0 || blk1 || bk_go;
    wire launch_nv = fc_copy0 || fc_copy1 || bk_go;
    wire [5:0] launch_first = blk0 ? `GMS_NV_UB_FIRST
                            : (blk1 ? `GMS_NV_PB_FIRST : `GMS_NV_BK_FIRST);
    wire [5:0] launch_last  = blk0 ? `GMS_NV_UB_LAST
                            : (blk1 ? `GMS_NV_PB_LAST : `GMS_NV_BK_LAST);

    // ************************************************************
    // block transfer engine
    // ************************************************************
    // the address cell is stored relative to the factory value
    wire [7:0] fix = (xf_pidx == `GMS_NV_SLAVE) ? {`GMS_SLAVE_DFLT, 1'b0} : 8'h00;
    wire       xw       = xfer_act && xf_pend;
    wire [7:0] xf_data  = (xf_to_nv ? sh.rdata : nv.rdata) ^ fix;
    wire       xf_sh_we = xw && !xf_to_nv && (xf_pidx != `GMS_NV_LOCK);
    wire       xf_lock  = xw && !xf_to_nv && (xf_pidx == `GMS_NV_LOCK);
    wire       xf_slave = xf_sh_we && (xf_pidx == `GMS_NV_SLAVE);
    wire       xf_done  = xfer_act && !xf_run && !xf_pend;

    assign nv.raddr = xf_idx;
    assign nv.we    = (xw && xf_to_nv) || (state == ST_LOCKW); // R15 R16 R5
    assign nv.waddr = (state == ST_LOCKW) ? `GMS_NV_LOCK : xf_pidx;
    assign nv.wdata = (state == ST_LOCKW)
                      ? {6'h00, param_block_lock_flag, user_block_lock_flag}
                      : xf_data;

    // ************************************************************
    // shadow RAM port
    // ************************************************************
    wire rd_hi = (state == ST_RD) && is_pair; // R12
    assign sh.raddr = xfer_act ? nv2sh(xf_idx)
                    : (rd_hi ? {bus_addr[7:1], 1'b1} : bus_addr); // R10
    assign sh.we    = xf_sh_we || ram_hw || meas_take; // R15 R18 R19
    assign sh.waddr = xf_sh_we ? nv2sh(xf_pidx) : (meas_take ? meas_addr : bus_addr);
    assign sh.wdata = xf_sh_we ? xf_data : (meas_take ? meas_data : bus_wdata);

    wire [7:0] ctl_byte = {6'h00, param_block_lock_flag, user_block_lock_flag}; // R1 R22
    wire       lat_hit  = lat_ok && (bus_addr == lat_addr);
    wire [7:0] rd_val   = a_sfr ? special_feature_reg
                        : (a_nvctl ? ctl_byte
                        : (lat_hit ? lat_lsb : sh.rdata)); // R11 R23
    wire remaining_relative_capacity_cross = remaining_relative_capacity_seen
                      && (remaining_relative_capacity[7:`GMS_REMAINING_RELATIVE_CAPACITY_STEP_LSB] != remaining_relative_capacity_bkt);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            ST_INIT:  next_state = xf_done ? ST_IDLE : ST_INIT; // R25
            ST_IDLE:
            begin
                if (launch)
                    next_state = ST_XFER; // R24 R21
                else if (fc_lock0 || fc_lock1)
                    next_state = ST_LOCKW;
                else if (hr)
                    next_state = ST_RD;
            end
            ST_RD:    next_state = is_pair ? ST_RDLSB : ST_IDLE;
            ST_RDLSB: next_state = ST_IDLE;
            ST_XFER:  next_state = xf_done ? ST_IDLE : ST_XFER;
            ST_LOCKW: next_state = ST_IDLE;
            default:  next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state      <= ST_INIT;
            meas_ready <= 1'b0;
        end
        else if (ce)
        begin
            state      <= next_state;
            meas_ready <= (next_state == ST_IDLE);
        end
    end

    // power-up load covers every block and the lock byte
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            xf_run   <= 1'b1;
            xf_idx   <= `GMS_NV_UB_FIRST;
            xf_last  <= `GMS_NV_LOCK;
            xf_to_nv <= 1'b0;
            xf_pend  <= 1'b0;
            xf_pidx  <= 6'h00;
        end
        else if (ce)
        begin
            xf_pend <= xfer_act && xf_run;
            xf_pidx <= xf_idx;
            if (launch)
            begin
                xf_run   <= 1'b1;
                xf_idx   <= launch_first;
                xf_last  <= launch_last;
                xf_to_nv <= launch_nv;
            end
            else if (xfer_act && xf_run)
            begin
                xf_run <= (xf_idx != xf_last);
                xf_idx <= 6'(xf_idx + 6'h01);
            end
        end
    end

    // ************************************************************
    // control bits, slave address, lock flags
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            special_feature_reg                   <= `GMS_SFR_RST;
            slave_addr_bits       <= `GMS_SLAVE_DFLT; // R9
            user_block_lock_flag  <= 1'b0;
            param_block_lock_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_sfr)
                special_feature_reg <= bus_wdata; // R23
            if (wr_slave)
                slave_addr_bits <= bus_wdata[7:1]; // R3 R4 R8
            else if (xf_slave)
                slave_addr_bits <= xf_data[7:1]; // R2 R6
            if (xf_lock)
            begin
                user_block_lock_flag  <= nv.rdata[`GMS_BIT_UB_LOCK];
                param_block_lock_flag <= nv.rdata[`GMS_BIT_PB_LOCK];
            end
            if (fc_lock0)
                user_block_lock_flag <= 1'b1;
            if (fc_lock1)
                param_block_lock_flag <= 1'b1;
        end
    end

    // ************************************************************
    // host answers and pair capture
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            bus_ack   <= 1'b0;
            bus_rdata <= 8'h00;
            lat_lsb   <= 8'h00;
            lat_addr  <= 8'h00;
            lat_ok    <= 1'b0;
        end
        else if (ce)
        begin
            bus_ack <= hw || ((state == ST_RD) && !is_pair) || (state == ST_RDLSB);
            if (state == ST_RD)
                bus_rdata <= rd_val;
            if (state == ST_RDLSB)
            begin
                lat_lsb  <= sh.rdata; // R13
                lat_addr <= {bus_addr[7:1], 1'b1};
                lat_ok   <= 1'b1;
            end
            else if (bus_cmd_end)
                lat_ok <= 1'b0;
        end
    end

    // ************************************************************
    // capacity boundary backup
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            remaining_relative_capacity_seen <= 1'b0;
            remaining_relative_capacity_bkt  <= 6'h00;
            bk_pend   <= 1'b0;
        end
        else if (ce)
        begin
            remaining_relative_capacity_seen <= !xfer_act || remaining_relative_capacity_seen;
            remaining_relative_capacity_bkt  <= remaining_relative_capacity[7:`GMS_REMAINING_RELATIVE_CAPACITY_STEP_LSB];
            bk_pend   <= remaining_relative_capacity_cross || (bk_pend && !bk_go); // R21
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset || !ce);

    sequence s_pair_read;
        hr && is_pair && !launch && !fc_lock0 && !fc_lock1;
    endsequence
    sequence s_pair_done;
        (state == ST_RD) ##1 (state == ST_RDLSB) ##1 (bus_ack && lat_ok);
    endsequence
    a_ub_lock_read: assert property ( // R1
        (state == ST_RD) && a_nvctl |=> bus_rdata[0] == $past(user_block_lock_flag))
        else $error("user lock flag misread");
    a_pb_lock_read: assert property ( // R22
        (state == ST_RD) && a_nvctl |=> bus_rdata[1] == $past(param_block_lock_flag))
        else $error("parameter lock flag misread");
    a_addr_new: assert property ( // R4
        hw && a_slave && addr_we |=> slave_addr_bits == $past(bus_wdata[7:1]))
        else $error("slave address not taken");
    a_addr_held: assert property ( // R3
        hw && a_slave && !addr_we && !xfer_act |=> $stable(slave_addr_bits))
        else $error("slave address changed without enable");
    a_ub_refused: assert property ( // R19
        hw && ub_refuse |=> bus_ack && (state == ST_IDLE))
        else $error("refused write not acknowledged");
    a_ub_no_write: assert property ( // R19
        hw && ub_refuse |-> !(sh.we && (sh.waddr == bus_addr) && !meas_take))
        else $error("locked user block written");
    a_copy_locked: assert property ( // R26
        wr_fc && (((bus_wdata == `GMS_FC_COPY0) && user_block_lock_flag)
        || ((bus_wdata == `GMS_FC_COPY1) && param_block_lock_flag))
        |=> (state == ST_IDLE) && !nv.we)
        else $error("copy ran on locked block");
    a_pair_latch: assert property ( // R13
        s_pair_read |=> s_pair_done)
        else $error("pair capture sequence broken");
    a_cells_quiet: assert property ( // R15
        nv.we |-> (state == ST_XFER) || (state == ST_LOCKW))
        else $error("cells written outside a transfer");
    a_init_quiet: assert property ( // R25
        (state == ST_INIT) |-> !bus_ack && !meas_ready)
        else $error("served before power-up load");
    a_backup_go: assert property ( // R21
        bk_go |=> (state == ST_XFER) && xf_to_nv && (xf_idx == `GMS_NV_BK_FIRST))
        else $error("backup did not start");
endmodule // gms_gauge_mem

`default_nettype wire

// [inc/gms_consts.svh]
`ifndef GMS_CONSTS_SVH
`define GMS_CONSTS_SVH

// ************************************************************
// byte map of the host space
// ************************************************************
`define GMS_ADDR_ACC_MSB  8'h10
`define GMS_ADDR_ACC_LSB  8'h11
`define GMS_ADDR_AGE      8'h14
`define GMS_ADDR_SFR      8'h15
`define GMS_ADDR_NVCTL    8'h1F
`define GMS_ADDR_REMAINING_RELATIVE_CAPACITY     8'h06
`define GMS_ADDR_SLAVE    8'h7E
`define GMS_ADDR_FCMD     8'hFE
`define GMS_UB_BASE       8'h20
`define GMS_UB_LAST       8'h2F
`define GMS_PB_BASE       8'h60
`define GMS_PAIR_LO       8'h02
`define GMS_PAIR_HI       8'h1B

// ************************************************************
// field positions and reset values
// ************************************************************
`define GMS_BIT_UB_LOCK   0
`define GMS_BIT_PB_LOCK   1
`define GMS_BIT_ADDR_WE   1
`define GMS_SFR_RST       8'h00
`define GMS_SLAVE_DFLT    7'h34
`define GMS_REMAINING_RELATIVE_CAPACITY_STEP_LSB 2

// ************************************************************
// nonvolatile cell indices
// ************************************************************
`define GMS_NV_UB_FIRST   6'h00
`define GMS_NV_UB_LAST    6'h0F
`define GMS_NV_PB_FIRST   6'h10
`define GMS_NV_PB_LAST    6'h2F
`define GMS_NV_SLAVE      6'h2E
`define GMS_NV_BK_FIRST   6'h30
`define GMS_NV_BK_ACC_LSB 6'h31
`define GMS_NV_BK_LAST    6'h32
`define GMS_NV_LOCK       6'h33

// ************************************************************
// function command codes
// ************************************************************
`define GMS_FC_COPY0      8'h10
`define GMS_FC_COPY1      8'h11
`define GMS_FC_RECALL0    8'h20
`define GMS_FC_RECALL1    8'h21
`define GMS_FC_LOCK0      8'h30
`define GMS_FC_LOCK1      8'h31

`endif

// [inc/gms_pkg.sv]
`default_nettype none

package gms_pkg;

    typedef logic [7:0] gms_byte_t;

    typedef enum logic [5:0] {
        ST_INIT  = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_RD    = 6'b000100,
        ST_RDLSB = 6'b001000,
        ST_XFER  = 6'b010000,
        ST_LOCKW = 6'b100000
    } gms_state_t;

endpackage

`default_nettype wire

// [inc/gms_mem_if.sv]
`default_nettype none

interface gms_mem_if #(parameter int AW = 8) ();
    logic            we;
    logic [AW-1:0]   waddr;
    logic [7:0]      wdata;
    logic [AW-1:0]   raddr;
    logic [7:0]      rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// [logic/gms_nv_mem.sv]
`default_nettype none

module gms_nv_mem #(
    parameter int AW = 8
) (
    input  wire logic sys_clk,
    input  wire logic ce,
    gms_mem_if.mem    port
);
    logic [7:0] cells [2**AW];

    // cleared cells stand for the factory state
    initial
    begin
        for (int i = 0; i < 2**AW; i++)
        begin
            cells[i] = 8'h00;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (ce)
        begin
            if (port.we)
            begin
                cells[port.waddr] <= port.wdata;
            end
            port.rdata <= cells[port.raddr];
        end
    end
endmodule // gms_nv_mem

`default_nettype wire

// [test/gms_host_model.sv]
`include "gms_consts.svh"
`default_nettype none

module gms_host_model (
    input  wire logic       sys_clk,
    input  wire logic       bus_ack,
    input  wire logic [7:0] bus_rdata,
    input  wire logic       meas_ready,
    output var  logic       bus_req,
    output var  logic       bus_wr,
    output var  logic [7:0] bus_addr,
    output var  logic [7:0] bus_wdata,
    output var  logic       bus_cmd_end
);
    timeunit 1ns;
    timeprecision 1ns;

    int lost = 0;

    initial
    begin
        bus_req     = 1'b0;
        bus_wr      = 1'b0;
        bus_addr    = 8'h00;
        bus_wdata   = 8'h00;
        bus_cmd_end = 1'b0;
    end

    function automatic logic reserved(input logic [7:0] a);
        return a inside {[8'h1C:8'h1E], [8'h38:8'h5F], 8'h7D, 8'h7F, [8'h80:8'hFD], 8'hFF};
    endfunction

    // ************************************************************
    // one request held until acknowledged
    // ************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        n = 0;
        @(negedge sys_clk);
        bus_req   = 1'b1;
        bus_wr    = w;
        bus_addr  = a;
        bus_wdata = d;
        while (bus_ack !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 200)
            lost++;
        q = bus_rdata;
        @(negedge sys_clk);
        bus_req   = 1'b0;
        // released lines must not keep looking valid
        bus_addr  = ~a;
        bus_wdata = ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        if (reserved(a))
            return;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask

    task automatic end_cmd();
        @(negedge sys_clk);
        bus_cmd_end = 1'b1;
        @(negedge sys_clk);
        bus_cmd_end = 1'b0;
    endtask

    task automatic set_slave(input logic [6:0] s);
        wr(`GMS_ADDR_SFR, 8'h01 << `GMS_BIT_ADDR_WE);
        wr(`GMS_ADDR_SLAVE, {s, 1'b0});
        wr(`GMS_ADDR_SFR, 8'h00);
    endtask

    task automatic func(input logic [7:0] code);
        int n;
        n = 0;
        wr(`GMS_ADDR_FCMD, code);
        repeat (3) @(negedge sys_clk);
        while (meas_ready !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
endmodule // gms_host_model

`default_nettype wire

// [test/tb_top.sv]
`include "gms_consts.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic       sys_clk;
    logic       reset;
    logic       ce;
    logic       bus_req;
    logic       bus_wr;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic       bus_cmd_end;
    logic       bus_ack;
    logic [7:0] bus_rdata;
    logic       meas_we;
    logic [7:0] meas_addr;
    logic [7:0] meas_data;
    logic       meas_ready;
    logic [7:0] rrc;
    logic [6:0] slave_addr_bits;
    logic       ub_lock;
    logic       pb_lock;
    logic [7:0] q;
    int         fails = 0;
    int         num_checks = 0;
    int         cycles = 0;

    gms_gauge_mem i_gms_gauge_mem (
        .sys_clk(sys_clk), .reset(reset), .ce(ce), .bus_req(bus_req), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_cmd_end(bus_cmd_end),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .meas_we(meas_we), .meas_addr(meas_addr),
        .meas_data(meas_data), .meas_ready(meas_ready), .remaining_relative_capacity(rrc),
        .slave_addr_bits(slave_addr_bits), .user_block_lock_flag(ub_lock),
        .param_block_lock_flag(pb_lock)
    );

    gms_host_model i_gms_host_model (
        .sys_clk(sys_clk), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .meas_ready(meas_ready),
        .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_cmd_end(bus_cmd_end)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fails++;
            complete_run();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic complete_run();
        fails += i_gms_host_model.lost;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        i_gms_host_model.rd(a, q);
        check8("read data", exp, q);
    endtask

    task automatic power_up();
        int n;
        n = 0;
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (20) @(negedge sys_clk);
        check8("address in reset", {1'b0, `GMS_SLAVE_DFLT}, {1'b0, slave_addr_bits});
        check8("ready in reset", 8'h00, {7'h00, meas_ready});
        reset = 1'b0;
        while (meas_ready !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power_on();
        power_up();
        check8("address", 8'h34, {1'b0, slave_addr_bits});
        check8("lock flags", 8'h00, {6'h00, pb_lock, ub_lock});
        rd_check(`GMS_ADDR_NVCTL, 8'h00);
        $display("test power_on done");
    endtask

    task automatic t_slave_addr();
        i_gms_host_model.wr(`GMS_ADDR_SLAVE, 8'hA4);
        check8("address no enable", 8'h34, {1'b0, slave_addr_bits});
        i_gms_host_model.wr(`GMS_ADDR_SFR, 8'h02);
        rd_check(`GMS_ADDR_SFR, 8'h02);
        i_gms_host_model.wr(`GMS_ADDR_SLAVE, 8'hA5);
        check8("address enabled", 8'h52, {1'b0, slave_addr_bits});
        i_gms_host_model.wr(`GMS_ADDR_SFR, 8'h00);
        power_up();
        check8("address not copied", 8'h34, {1'b0, slave_addr_bits});
        i_gms_host_model.set_slave(7'h1B);
        i_gms_host_model.func(`GMS_FC_COPY1);
        power_up();
        check8("address copied", 8'h1B, {1'b0, slave_addr_bits});
        $display("test slave_addr done");
    endtask

    task automatic t_user_block();
        for (int i = 0; i < 16; i++)
            i_gms_host_model.wr(8'(`GMS_UB_BASE + i), 8'(8'hC0 + i));
        i_gms_host_model.func(`GMS_FC_COPY0);
        for (int i = 0; i < 16; i++)
            i_gms_host_model.wr(8'(`GMS_UB_BASE + i), 8'h00);
        rd_check(8'h25, 8'h00);
        i_gms_host_model.func(`GMS_FC_RECALL0);
        for (int i = 0; i < 16; i++)
            rd_check(8'(`GMS_UB_BASE + i), 8'(8'hC0 + i));
        check8("address kept", 8'h1B, {1'b0, slave_addr_bits});
        i_gms_host_model.func(`GMS_FC_LOCK0);
        check8("user lock", 8'h01, {7'h00, ub_lock});
        i_gms_host_model.wr(`GMS_ADDR_NVCTL, 8'h00);
        rd_check(`GMS_ADDR_NVCTL, 8'h01);
        i_gms_host_model.wr(8'h23, 8'h77);
        rd_check(8'h23, 8'hC3);
        $display("test user_block done");
    endtask

    task automatic t_pair();
        i_gms_host_model.wr(`GMS_ADDR_ACC_MSB, 8'h12);
        i_gms_host_model.wr(`GMS_ADDR_ACC_LSB, 8'h34);
        rd_check(`GMS_ADDR_ACC_MSB, 8'h12);
        @(negedge sys_clk);
        meas_we   = 1'b1;
        meas_addr = `GMS_ADDR_ACC_LSB;
        meas_data = 8'h56;
        @(negedge sys_clk);
        meas_we   = 1'b0;
        rd_check(`GMS_ADDR_ACC_LSB, 8'h34);
        ce = 1'b0;
        i_gms_host_model.end_cmd();
        ce = 1'b1;
        rd_check(`GMS_ADDR_ACC_LSB, 8'h34);
        i_gms_host_model.end_cmd();
        rd_check(`GMS_ADDR_ACC_LSB, 8'h56);
        $display("test pair done");
    endtask

    task automatic t_backup();
        i_gms_host_model.wr(`GMS_ADDR_ACC_MSB, 8'hAB);
        i_gms_host_model.wr(`GMS_ADDR_ACC_LSB, 8'hCD);
        i_gms_host_model.wr(`GMS_ADDR_AGE, 8'h5A);
        @(negedge sys_clk);
        rrc = 8'h30;
        i_gms_host_model.func(8'h00);
        i_gms_host_model.wr(`GMS_ADDR_ACC_MSB, 8'h00);
        power_up();
        rd_check(`GMS_ADDR_ACC_MSB, 8'hAB);
        rd_check(`GMS_ADDR_ACC_LSB, 8'hCD);
        i_gms_host_model.end_cmd();
        rd_check(`GMS_ADDR_AGE, 8'h5A);
        $display("test backup done");
    endtask

    task automatic t_param_lock();
        i_gms_host_model.wr(8'h61, 8'h3C);
        i_gms_host_model.func(`GMS_FC_COPY1);
        i_gms_host_model.func(`GMS_FC_LOCK1);
        check8("param lock", 8'h01, {7'h00, pb_lock});
        rd_check(`GMS_ADDR_NVCTL, 8'h03);
        i_gms_host_model.wr(8'h61, 8'hC3);
        i_gms_host_model.func(`GMS_FC_COPY1);
        i_gms_host_model.func(`GMS_FC_RECALL1);
        rd_check(8'h61, 8'h3C);
        $display("test param_lock done");
    endtask

    initial
    begin
        reset     = 1'b1;
        ce        = 1'b1;
        meas_we   = 1'b0;
        meas_addr = 8'h00;
        meas_data = 8'h00;
        rrc       = 8'h34;
        t_power_on();
        t_slave_addr();
        t_user_block();
        t_pair();
        t_backup();
        t_param_lock();
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
